/* bench/swt_timer_props.sv */
// Checker: concurrent properties on the stabilization watchdog timer ports
`timescale 1ns/1ps

module swt_timer_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        wdt_reset,
  input wire logic        cpu_clk_en,
  input wire logic        stable_done,
  input wire logic        gp_pre_tick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Last taken write address
  // ==========================================================================
  logic [11:0] aw_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_reg <= s_axi_awaddr;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  a_wdt_single_pulse: assert property (wdt_reset |=> !wdt_reset)
    else $error("watchdog reset longer than one cycle");
  a_wdt_in_run: assert property (wdt_reset |-> $past(cpu_clk_en))
    else $error("watchdog reset outside normal run");
  a_wdt_restabilize: assert property (wdt_reset |-> ##[1:4] !cpu_clk_en)
    else $error("block not reinitialized after watchdog reset");
  a_done_single: assert property (stable_done |=> !stable_done)
    else $error("stabilization done longer than one cycle");
  a_done_releases: assert property (stable_done |-> ##[0:2] cpu_clk_en)
    else $error("cpu clock not released after stabilization");
  a_release_cause: assert property ($rose(cpu_clk_en) |-> stable_done || $past(stable_done))
    else $error("cpu clock released without stabilization done");
  a_count_write_err: assert property (s_axi_bvalid && aw_reg == swt_pkg::COUNT_ADDR
    |-> s_axi_bresp == swt_pkg::RESP_SLVERR)
    else $error("count register write accepted");
  a_ctrl_write_ok: assert property (s_axi_bvalid && aw_reg == swt_pkg::CTRL_ADDR
    |-> s_axi_bresp == swt_pkg::RESP_OKAY)
    else $error("control register write refused");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
  a_gp_tick_pulse: assert property (gp_pre_tick |=> !gp_pre_tick)
    else $error("general prescaler tick longer than one cycle");

  c_wdt: cover property (wdt_reset);
  c_done: cover property (stable_done);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == swt_pkg::RESP_SLVERR);
endmodule // swt_timer_props

bind swt_timer swt_timer_props u_props (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .wdt_reset(wdt_reset), .cpu_clk_en(cpu_clk_en), .stable_done(stable_done),
  .gp_pre_tick(gp_pre_tick)
);

/* bench/swt_timer_test.sv */
// Testbench: register, stabilization, stop wake and watchdog sequences
`timescale 1ns/1ps

module swt_timer_test;
  logic        core_clk, rst_n, stop_mode, ext_wake;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        wdt_reset, cpu_clk_en, stable_done, gp_pre_tick, irq;
  int          mismatches = 0, cmp_count = 0, cyc = 0, wdt_cnt = 0, done_cnt = 0;
  int          t0, n;
  localparam int SH = 4;
  int          divs[3] = '{4096 >> SH, 1024 >> SH, 128 >> SH};

  swt_timer #(.DIV_SHIFT(SH)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .stop_mode(stop_mode), .ext_wake(ext_wake),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdt_reset(wdt_reset),
    .cpu_clk_en(cpu_clk_en), .stable_done(stable_done), .gp_pre_tick(gp_pre_tick), .irq(irq)
  );

  // ==========================================================================
  // Clock and event counters
  // ==========================================================================
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wdt_reset === 1'b1) wdt_cnt <= wdt_cnt + 1;
    if (stable_done === 1'b1) done_cnt <= done_cnt + 1;
  end

  // ==========================================================================
  // Checks and verdict
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic span(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Register bus master
  // ==========================================================================
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // ==========================================================================
  // Watchdog on the whole run
  // ==========================================================================
  initial begin
    #300_000;
    mismatches++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    stop_mode = 1'b0;
    ext_wake = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t0 = cyc;
    @(posedge core_clk);
    axi_read(swt_pkg::CTRL_ADDR, rd, rsp);
    check(rd, 32'h0000_0000);
    while (!cpu_clk_en && cyc - t0 < 40_000) @(posedge core_clk);
    span(cyc - t0, 128 * divs[0] - 8, 128 * divs[0] + 16);
    check(done_cnt, 1);
    repeat (2 * divs[0]) @(posedge core_clk);
    axi_write(swt_pkg::CTRL_ADDR, 8'h03, rsp);
    @(posedge core_clk);
    check(gp_pre_tick, 1'b0);
    @(posedge core_clk);
    check(gp_pre_tick, 1'b1);
    axi_write(swt_pkg::COUNT_ADDR, 8'h55, rsp);
    check(rsp, swt_pkg::RESP_SLVERR);
    axi_read(swt_pkg::COUNT_ADDR, rd, rsp);
    check(rd, 32'h0000_0000);
    axi_write(12'h004, 8'h11, rsp);
    check(rsp, swt_pkg::RESP_SLVERR);
    axi_write(swt_pkg::CTRL_ADDR, 8'hAB, rsp);
    axi_read(swt_pkg::CTRL_ADDR, rd, rsp);
    check(rd, 32'h0000_00A8);
    for (int s = 0; s < 3; s++) begin
      axi_write(swt_pkg::CTRL_ADDR, {4'hA, 2'(s), 2'b11}, rsp);
      repeat (3 * divs[s] + divs[s] / 2) @(posedge core_clk);
      axi_read(swt_pkg::COUNT_ADDR, rd, rsp);
      check(rd, 32'h0000_0003);
    end
    axi_write(swt_pkg::CTRL_ADDR, 8'hAB, rsp);
    n = wdt_cnt;
    repeat (256 * divs[2] + 512) @(posedge core_clk);
    check(wdt_cnt, n);
    axi_read(swt_pkg::IRQ_STAT_ADDR, rd, rsp);
    check(rd, 32'h0000_0001);
    axi_write(swt_pkg::IRQ_MASK_ADDR, 8'h03, rsp);
    repeat (3) @(posedge core_clk);
    check(irq, 1'b1);
    axi_write(swt_pkg::IRQ_STAT_ADDR, 8'h01, rsp);
    repeat (3) @(posedge core_clk);
    check(irq, 1'b0);
    axi_write(swt_pkg::WAKE_CTRL_ADDR, 8'h01, rsp);
    stop_mode <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(cpu_clk_en, 1'b0);
    stop_mode <= 1'b0;
    ext_wake <= 1'b1;
    t0 = cyc;
    n = done_cnt;
    while (!cpu_clk_en && cyc - t0 < 20_000) @(posedge core_clk);
    ext_wake <= 1'b0;
    span(cyc - t0, 127 * divs[2], 129 * divs[2] + 16);
    check(done_cnt, n + 1);
    check(irq, 1'b1);
    axi_write(swt_pkg::IRQ_STAT_ADDR, 8'h01, rsp);
    axi_write(swt_pkg::CTRL_ADDR, 8'h5B, rsp);
    t0 = cyc;
    n = wdt_cnt;
    while (wdt_cnt == n && cyc - t0 < 4_000) @(posedge core_clk);
    span(cyc - t0, 256 * divs[2] - 8, 256 * divs[2] + 16);
    repeat (4) @(posedge core_clk);
    check(cpu_clk_en, 1'b0);
    axi_read(swt_pkg::CTRL_ADDR, rd, rsp);
    check(rd, 32'h0000_0000);
    axi_read(swt_pkg::IRQ_STAT_ADDR, rd, rsp);
    check(rd[1], 1'b1);
    conclude();
  end
endmodule // swt_timer_test

/* inc/swt_pkg.sv */
// Package: register map, fields and timing constants of the stabilization watchdog timer
package swt_pkg;

  // ==========================================================================
  // Register map (printed offsets are not multiples of four: kept as indices)
  // ==========================================================================
  localparam logic [7:0]  CTRL_INDEX      = 8'hD3;
  localparam logic [7:0]  COUNT_INDEX     = 8'hFD;
  localparam logic [7:0]  IRQ_STAT_INDEX  = 8'hE0;
  localparam logic [7:0]  IRQ_MASK_INDEX  = 8'hE1;
  localparam logic [7:0]  WAKE_CTRL_INDEX = 8'hE2;
  localparam logic [11:0] CTRL_ADDR       = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [11:0] COUNT_ADDR      = {2'h0, COUNT_INDEX, 2'h0};
  localparam logic [11:0] IRQ_STAT_ADDR   = {2'h0, IRQ_STAT_INDEX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR   = {2'h0, IRQ_MASK_INDEX, 2'h0};
  localparam logic [11:0] WAKE_CTRL_ADDR  = {2'h0, WAKE_CTRL_INDEX, 2'h0};
  localparam int          ADDR_W          = 12;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam int         SIG_HI           = 7;
  localparam int         SIG_LO           = 4;
  localparam logic [3:0] SIG_DISABLE      = 4'hA;
  localparam int         SEL_HI           = 3;
  localparam int         SEL_LO           = 2;
  localparam int         CNT_CLR_BIT      = 1;
  localparam int         PRE_CLR_BIT      = 0;

  // Clock select codes
  typedef enum logic [1:0] {
    SWT_DIV_4096 = 2'h0,
    SWT_DIV_1024 = 2'h1,
    SWT_DIV_128  = 2'h2
  } swt_div_t;

  // ==========================================================================
  // Prescaler and counter
  // ==========================================================================
  localparam int         PRE_W            = 12;
  localparam int         DIV_4096_BIT     = 11;
  localparam int         DIV_1024_BIT     = 9;
  localparam int         DIV_128_BIT      = 6;
  localparam int         CNT_W            = 8;
  localparam int         CNT_MSB          = 7;

  // Interrupt status bits
  localparam int         IRQ_W            = 2;
  localparam int         IRQ_STABLE_BIT   = 0;
  localparam int         IRQ_OVF_BIT      = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage : swt_pkg

/* logic/swt_prescaler.sv */
// Module: free-running oscillator prescaler with divided tick selection
`timescale 1ns/1ps

module swt_prescaler #(
  parameter int PRE_W     = swt_pkg::PRE_W,
  parameter int DIV_SHIFT = 0
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sync_clr,
  input  wire logic [1:0] div_sel,
  output logic            tick,
  output logic            gp_tick
);

  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic             tap;

  // ==========================================================================
  // Divider chain
  // ==========================================================================
  assign pre_next = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else if (sync_clr) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // ==========================================================================
  // Tap selection
  // ==========================================================================
  // Divider multiplexer
  always_comb begin
    case (div_sel)
      swt_pkg::SWT_DIV_1024: tap = &pre_reg[swt_pkg::DIV_1024_BIT-DIV_SHIFT:0];
      swt_pkg::SWT_DIV_128:  tap = &pre_reg[swt_pkg::DIV_128_BIT-DIV_SHIFT:0];
      default:               tap = &pre_reg[swt_pkg::DIV_4096_BIT-DIV_SHIFT:0];
    endcase
  end

  assign tick    = tap & ~sync_clr;
  // General timer tick shares this chain
  assign gp_tick = pre_reg[0] & ~sync_clr;

endmodule // swt_prescaler

/* logic/swt_timer.sv */
// Module: stabilization watchdog timer with AXI4-Lite register slave
// What this block does
// - Reset loads control with zero: watchdog on, divide by 4096.
// - Watchdog reset disabled only while control bits 7..4 equal 1010.
// - Writing one to control bit 1 clears the counter.
// - Writing one to control bit 0 clears both prescalers.
// - Counter clock muxed from oscillator divided by 4096, 1024 or 128.
// - Count register is 8-bit, read-only; writes answered with SLVERR.
// - With watchdog on, counter bit 7 overflow triggers system reset.
// - After stop, counter counts at 4096 after reset or preset rate.
// - Stabilization ends when counter bit 7 sets; CPU clock released.
`timescale 1ns/1ps

module swt_timer #(
  parameter int CNT_W     = swt_pkg::CNT_W,
  parameter int DIV_SHIFT = 0
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Stop mode and wake pins
  input  wire logic        stop_mode,
  input  wire logic        ext_wake,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // System outputs
  output logic             wdt_reset,
  output logic             cpu_clk_en,
  output logic             stable_done,
  output logic             gp_pre_tick,
  output logic             irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [1:0] {
    SWT_RUN,
    SWT_STOPPED,
    SWT_STABILIZE
  } swt_state_t;

  swt_state_t               state_reg;
  logic [7:0]               ctrl_reg;
  logic [CNT_W-1:0]         count_reg;
  logic [CNT_W:0]           count_next;
  logic [swt_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [swt_pkg::IRQ_W-1:0] irq_mask_reg;
  logic                     force_4096_reg;
  logic                     wake_en_reg;
  logic                     stop_s1_reg;
  logic                     stop_s2_reg;
  logic                     wake_s1_reg;
  logic                     wake_s2_reg;
  logic                     wdt_pulse;
  logic                     wdt_rst_reg;
  logic                     aw_held_reg;
  logic                     w_held_reg;
  logic [11:0]              awaddr_reg;
  logic [31:0]              wdata_reg;
  logic [3:0]               wstrb_reg;
  logic                     wr_fire;
  logic                     cnt_clr;
  logic                     pre_clr;
  logic                     tick;
  logic                     gp_tick;
  logic                     wd_enabled;
  logic                     stable_event;
  logic [1:0]               div_sel;
  logic [7:0]               wbyte;
  logic [swt_pkg::IRQ_W-1:0] irq_set;

  // Address match to a register (bits 11..2), for reads and writes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction

  // ==========================================================================
  // Internal reset and synchronisers
  // ==========================================================================
  // Block reinitialised by watchdog pulse
  logic blk_rst_n;
  assign blk_rst_n = rst_n & ~wdt_rst_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end else begin
      stop_s1_reg <= stop_mode;
      stop_s2_reg <= stop_s1_reg;
      wake_s1_reg <= ext_wake;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wbyte   = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= swt_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (hit(awaddr_reg, swt_pkg::CTRL_ADDR) || hit(awaddr_reg, swt_pkg::IRQ_STAT_ADDR)
            || hit(awaddr_reg, swt_pkg::IRQ_MASK_ADDR)
            || hit(awaddr_reg, swt_pkg::WAKE_CTRL_ADDR)) begin
          s_axi_bresp <= swt_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= swt_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  assign cnt_clr = wr_fire & wstrb_reg[0] & hit(awaddr_reg, swt_pkg::CTRL_ADDR)
                   & wbyte[swt_pkg::CNT_CLR_BIT];
  assign pre_clr = wr_fire & wstrb_reg[0] & hit(awaddr_reg, swt_pkg::CTRL_ADDR)
                   & wbyte[swt_pkg::PRE_CLR_BIT];

  always_ff @(posedge core_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      ctrl_reg <= swt_pkg::CTRL_RESET;
    end else if (wr_fire && wstrb_reg[0] && hit(awaddr_reg, swt_pkg::CTRL_ADDR)) begin
      // Clear bits are self-clearing
      ctrl_reg <= {wbyte[swt_pkg::SIG_HI:swt_pkg::SEL_LO], 2'b00};
    end
  end

  assign wd_enabled = (ctrl_reg[swt_pkg::SIG_HI:swt_pkg::SIG_LO] != swt_pkg::SIG_DISABLE);

  // ==========================================================================
  // Interrupt and wake control
  // ==========================================================================
  always_ff @(posedge core_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      irq_mask_reg <= '0;
      wake_en_reg  <= 1'b0;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (hit(awaddr_reg, swt_pkg::IRQ_MASK_ADDR)) begin
        irq_mask_reg <= wbyte[swt_pkg::IRQ_W-1:0];
      end
      if (hit(awaddr_reg, swt_pkg::WAKE_CTRL_ADDR)) begin
        wake_en_reg <= wbyte[0];
      end
    end
  end

  assign irq_set = {wdt_pulse, stable_event};
  // Set wins over write-one clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      if (wr_fire && wstrb_reg[0] && hit(awaddr_reg, swt_pkg::IRQ_STAT_ADDR)) begin
        irq_stat_reg <= (irq_stat_reg & ~wbyte[swt_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Prescaler
  // ==========================================================================
  // Select code or forced 4096
  assign div_sel = force_4096_reg ? swt_pkg::SWT_DIV_4096
                                  : ctrl_reg[swt_pkg::SEL_HI:swt_pkg::SEL_LO];

  swt_prescaler #(
    .PRE_W     (swt_pkg::PRE_W),
    .DIV_SHIFT (DIV_SHIFT)
  ) u_prescaler (
    .core_clk (core_clk),
    .rst_n    (blk_rst_n),
    .sync_clr (pre_clr),
    .div_sel  (div_sel),
    .tick     (tick),
    .gp_tick  (gp_tick)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_pre_tick <= 1'b0;
    end else begin
      gp_pre_tick <= gp_tick;
    end
  end

  // ==========================================================================
  // Stop and stabilization sequence
  // ==========================================================================
  assign stable_event = (state_reg == SWT_STABILIZE) & count_reg[swt_pkg::CNT_MSB];

  always_ff @(posedge core_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      state_reg      <= SWT_STABILIZE;
      force_4096_reg <= 1'b1;
    end else begin
      case (state_reg)
        SWT_RUN: begin
          if (stop_s2_reg) begin
            state_reg <= SWT_STOPPED;
          end
        end
        SWT_STOPPED: begin
          if (wake_s2_reg && wake_en_reg) begin
            state_reg      <= SWT_STABILIZE;
            force_4096_reg <= 1'b0;
          end
        end
        SWT_STABILIZE: begin
          if (count_reg[swt_pkg::CNT_MSB]) begin
            state_reg      <= SWT_RUN;
            force_4096_reg <= 1'b0;
          end
        end
        default: state_reg <= SWT_RUN;
      endcase
    end
  end

  // ==========================================================================
  // Counter and watchdog
  // ==========================================================================
  assign count_next = {1'b0, count_reg} + {{CNT_W{1'b0}}, 1'b1};
  // Overflow out of bit 7 resets
  assign wdt_pulse  = (state_reg == SWT_RUN) & wd_enabled & tick & count_next[CNT_W]
                      & ~cnt_clr & ~wdt_rst_reg;

  always_ff @(posedge core_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      count_reg <= '0;
    end else if (state_reg == SWT_STOPPED) begin
      count_reg <= '0;
    end else if (cnt_clr || (state_reg == SWT_STABILIZE && count_reg[swt_pkg::CNT_MSB])) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_next[CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_rst_reg <= 1'b0;
    end else begin
      wdt_rst_reg <= wdt_pulse;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset   <= 1'b0;
      cpu_clk_en  <= 1'b0;
      stable_done <= 1'b0;
    end else begin
      wdt_reset   <= wdt_pulse;
      cpu_clk_en  <= (state_reg == SWT_RUN) & ~wdt_pulse;
      stable_done <= stable_event;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= swt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= swt_pkg::RESP_OKAY;
        s_axi_rdata  <= '0;
        if (hit(s_axi_araddr, swt_pkg::CTRL_ADDR)) begin
          s_axi_rdata[7:0] <= ctrl_reg;
        end else if (hit(s_axi_araddr, swt_pkg::COUNT_ADDR)) begin
          s_axi_rdata[CNT_W-1:0] <= count_reg;
        end else if (hit(s_axi_araddr, swt_pkg::IRQ_STAT_ADDR)) begin
          s_axi_rdata[swt_pkg::IRQ_W-1:0] <= irq_stat_reg;
        end else if (hit(s_axi_araddr, swt_pkg::IRQ_MASK_ADDR)) begin
          s_axi_rdata[swt_pkg::IRQ_W-1:0] <= irq_mask_reg;
        end else if (hit(s_axi_araddr, swt_pkg::WAKE_CTRL_ADDR)) begin
          s_axi_rdata[0] <= wake_en_reg;
        end else begin
          s_axi_rresp <= swt_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // swt_timer
